// *** test/rrc_exec_core_assertions.sv ***
`default_nettype none
module rrc_exec_core_chk
	import rrc_exec_pkg::*;
(
	input wire logic        CLK_I,
	input wire logic        SRST_I,
	input wire logic [4:0]  AVS_ADDRESS_I,
	input wire logic        AVS_READ_I,
	input wire logic        AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0]  AVS_BYTEENABLE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic        AVS_WAITREQUEST_O,
	input wire logic        BUSY_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	// Whole instruction word taken while idle
	wire logic go = AVS_WRITE_I && !BUSY_O && AVS_ADDRESS_I == OFF_INSTR && AVS_BYTEENABLE_I == 4'hF;
	wire logic ok = AVS_WRITEDATA_I[15:10] == RRC_OPCODE;
	a_exec_four_q: assert property (go && ok |=> BUSY_O [*4] ##1 !BUSY_O)
		else $error("rotate did not take four phases");
	a_bad_op_short: assert property (go && !ok |=> BUSY_O ##1 !BUSY_O)
		else $error("foreign opcode not dropped in one cycle");
	a_idle_stays: assert property (!BUSY_O && !(AVS_WRITE_I && AVS_ADDRESS_I == OFF_INSTR)
		|=> !BUSY_O)
		else $error("busy without instruction");
	a_busy_stalls: assert property (BUSY_O && (AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O)
		else $error("request not stalled while busy");
	a_write_no_wait: assert property (AVS_WRITE_I && !BUSY_O |-> !AVS_WAITREQUEST_O)
		else $error("idle write stalled");
	a_read_one_wait: assert property (AVS_READ_I && !$past(AVS_READ_I) && !BUSY_O
		|-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
		else $error("read wait not one cycle");
	a_rdata_holds: assert property ($changed(AVS_READDATA_O) |-> $past(AVS_READ_I))
		else $error("read data moved without read");
	a_busy_ends: assert property (BUSY_O |-> ##[1:4] !BUSY_O)
		else $error("busy longer than four cycles");
endmodule

bind rrc_exec_core rrc_exec_core_chk rrc_exec_core_chk_i (.CLK_I(CLK_I), .SRST_I(SRST_I),
	.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
	.AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .BUSY_O(BUSY_O));
`default_nettype wire

// *** test/rrc_exec_core_bench.sv ***
`default_nettype none
module rrc_exec_core_bench
	import rrc_exec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, srst, rd, wr, wait_o, busy;
	logic [4:0]  addr;
	logic [3:0]  be;
	logic [31:0] wdata, rdata;
	int          miscompares, compares, cycles = 0;

	rrc_exec_core rrc_exec_core_i (.CLK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_o), .BUSY_O(busy));

	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			test_done;
		end
	end

	task automatic test_done;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Idle edge first, so a release and a new request never share a time step
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		do @(posedge clk); while (wait_o !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdchk(input string n, input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(n, e, q);
	endtask

	// One instruction: seed memory, flags and accumulator, run, judge every effect
	task automatic run_op(input logic [5:0] op, input logic d, input logic a,
		input logic [7:0] f, input logic [11:0] ea, input logic [7:0] v, input logic c);
		logic [7:0] res;
		logic       ok;
		int         n;
		ok = op == RRC_OPCODE;
		res = {c, v[7:1]};
		n = 0;
		wreg(OFF_MEM_ADDR, {20'h0_0000, ea});
		wreg(OFF_MEM_DATA, {24'h00_0000, v});
		wreg(OFF_STATUS, {27'h000_0000, 4'h5, c});
		wreg(OFF_ACCUM, 32'h0000_005A);
		wreg(OFF_INSTR, {16'h0000, op, d, a, f});
		repeat (6) begin
			@(posedge clk);
			if (busy === 1'b1)
				n++;
		end
		chk("busy cycles", ok ? 4 : 1, n);
		rdchk("instr", OFF_INSTR, {14'h0000, !ok, 1'b0, op, d, a, f});
		rdchk("accum", OFF_ACCUM, {24'h00_0000, (ok && !d) ? res : 8'h5A});
		wreg(OFF_MEM_ADDR, {20'h0_0000, ea});
		rdchk("file reg", OFF_MEM_DATA, {24'h00_0000, (ok && d) ? res : v});
		rdchk("status", OFF_STATUS, {27'h000_0000, ok ? {res[7], 1'b1, res == 8'h00,
			1'b1, v[0]} : {4'h5, c}});
		$display("test done op %h d %b a %b f %h", op, d, a, f);
	endtask

	// Requests made mid-instruction stall until Q4 is done, then land
	task automatic stall_chk;
		wreg(OFF_INSTR, {16'h0000, RRC_OPCODE, 1'b0, 1'b1, 8'h00});
		wreg(OFF_ACCUM, 32'h0000_0033);
		rdchk("accum after stall", OFF_ACCUM, 32'h0000_0033);
		wreg(OFF_INSTR, {16'h0000, RRC_OPCODE, 1'b1, 1'b1, 8'h00});
		rdchk("instr after stall", OFF_INSTR, {16'h0000, RRC_OPCODE, 1'b1, 1'b1, 8'h00});
		$display("test done stall");
	endtask

	initial begin
		srst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = 5'h00;
		wdata = 32'h0000_0000;
		be = 4'hF;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rdchk("accum rst", OFF_ACCUM, 32'h0000_0000);
		rdchk("status rst", OFF_STATUS, 32'h0000_0000);
		rdchk("banksel rst", OFF_BANKSEL, 32'h0000_0000);
		be <= 4'h0;
		wreg(OFF_ACCUM, 32'h0000_00FF);
		be <= 4'hF;
		rdchk("masked write", OFF_ACCUM, 32'h0000_0000);
		$display("test done reset values");
		wreg(OFF_BANKSEL, 32'h0000_0003);
		run_op(RRC_OPCODE, 1'b0, 1'b1, 8'hFF, 12'h3FF, 8'hB6, 1'b1);
		run_op(RRC_OPCODE, 1'b1, 1'b0, 8'h10, 12'h010, 8'h01, 1'b0);
		run_op(RRC_OPCODE, 1'b1, 1'b0, 8'hA0, 12'hFA0, 8'h80, 1'b1);
		wreg(OFF_CONFIG, 32'h0000_0001);
		wreg(OFF_IDX_BASE, 32'h0000_0200);
		run_op(RRC_OPCODE, 1'b0, 1'b0, 8'h5F, 12'h25F, 8'h55, 1'b0);
		run_op(RRC_OPCODE, 1'b1, 1'b0, 8'h60, 12'hF60, 8'hC3, 1'b1);
		run_op(RRC_OPCODE, 1'b1, 1'b1, 8'h00, 12'h300, 8'h00, 1'b0);
		run_op(6'h0D, 1'b1, 1'b1, 8'h20, 12'h320, 8'h0F, 1'b1);
		stall_chk;
		test_done;
	end
endmodule
`default_nettype wire

// *** verilog/rotate_right_carry_unit.sv ***
`default_nettype none
module rotate_right_carry_unit (
	input  wire logic [7:0] operand_i,
	input  wire logic       carry_i,
	output logic      [7:0] result_o,
	output logic            carry_o,
	output logic            neg_o,
	output logic            zero_o
);

	// Old carry enters at the top, bit 0 leaves into carry
	assign result_o = {carry_i, operand_i[7:1]};
	assign carry_o  = operand_i[0];

	// Flags follow the rotated value, not the source
	assign neg_o  = result_o[7];
	assign zero_o = (result_o == 8'h00);

endmodule
`default_nettype wire

// *** verilog/rrc_exec_core.sv ***
`default_nettype none
module rrc_exec_core
	import rrc_exec_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int BANK_W = 4
) (
	input  wire logic        CLK_I,
	input  wire logic        SRST_I,
	input  wire logic [4:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	output logic             BUSY_O
);

	localparam int DEPTH = 1 << ADDR_W;

	// Data memory holding all file registers
	logic [7:0]        data_mem [DEPTH];

	exec_phase_e       phase_reg;
	logic [15:0]       instr_reg;
	logic              illegal_reg;
	logic [7:0]        accum_reg;
	logic [STATUS_W-1:0] status_reg;
	logic [BANK_W-1:0] banksel_reg;
	logic              ext_en_reg;
	logic [ADDR_W-1:0] idx_base_reg;
	logic [ADDR_W-1:0] mem_addr_reg;
	logic [ADDR_W-1:0] eff_addr_reg;
	logic [ADDR_W-1:0] eff_addr_next;
	logic              dest_reg;
	logic [7:0]        operand_reg;
	logic [7:0]        result_reg;
	logic              carry_res_reg;
	logic              neg_res_reg;
	logic              zero_res_reg;
	logic              rd_valid_reg;
	logic [31:0]       rd_next;
	logic              busy;
	logic              wr_ok;
	logic              rd_start;
	logic [31:0]       instr_wr;
	logic [31:0]       accum_wr;
	logic [31:0]       status_wr;
	logic [31:0]       banksel_wr;
	logic [31:0]       idx_base_wr;
	logic [31:0]       mem_addr_wr;
	logic [7:0]        alu_result;
	logic              alu_carry;
	logic              alu_neg;
	logic              alu_zero;

	// Byte-enable merge of bus write data over an old value
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return m;
	endfunction

	assign busy   = (phase_reg != PH_IDLE);
	assign BUSY_O = busy;

	// Bus is stalled during execution so software never races the Q4 write
	assign AVS_WAITREQUEST_O = (AVS_WRITE_I & busy) | (AVS_READ_I & ~rd_valid_reg);
	assign wr_ok    = AVS_WRITE_I & ~busy;
	assign rd_start = AVS_READ_I & ~busy & ~rd_valid_reg;

	// Lane-merged write values per register
	// Kept outside the clocked blocks so every register has one driver
	assign instr_wr    = be_merge(32'(instr_reg), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
	assign accum_wr    = be_merge(32'(accum_reg), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
	assign status_wr   = be_merge(32'(status_reg), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
	assign banksel_wr  = be_merge(32'(banksel_reg), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
	assign idx_base_wr = be_merge(32'(idx_base_reg), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
	assign mem_addr_wr = be_merge(32'(mem_addr_reg), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

	// Instruction phase sequencer, four clocks per rotate instruction, one for a foreign opcode
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			phase_reg <= PH_IDLE;
		end else begin
			case (phase_reg)
				PH_IDLE: begin
					if (wr_ok && AVS_ADDRESS_I == OFF_INSTR) begin
						phase_reg <= PH_Q1;
					end
				end
				PH_Q1: begin
					// Foreign opcodes end the cycle after Q1; only the illegal flag and the Q1 decode latches change
					if (instr_reg[15:POS_OPC_LO] == RRC_OPCODE) begin
						phase_reg <= PH_Q2;
					end else begin
						phase_reg <= PH_IDLE;
					end
				end
				PH_Q2: begin
					phase_reg <= PH_Q3;
				end
				PH_Q3: begin
					phase_reg <= PH_Q4;
				end
				PH_Q4: begin
					phase_reg <= PH_IDLE;
				end
				default: begin
					phase_reg <= PH_IDLE;
				end
			endcase
		end
	end

	// Instruction word and unknown-opcode flag
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			instr_reg   <= INSTR_RST;
			illegal_reg <= 1'b0;
		end else if (wr_ok && AVS_ADDRESS_I == OFF_INSTR) begin
			instr_reg   <= instr_wr[15:0];
			illegal_reg <= 1'b0;
		end else if (phase_reg == PH_Q1 && instr_reg[15:POS_OPC_LO] != RRC_OPCODE) begin
			illegal_reg <= 1'b1;
		end
	end

	// Address formation for the operand
	always_comb begin
		eff_addr_next = '0;
		if (instr_reg[POS_BANK]) begin
			eff_addr_next = ADDR_W'({banksel_reg, instr_reg[7:0]});
		end else if (ext_en_reg && instr_reg[7:0] <= IDX_THRESHOLD) begin
			eff_addr_next = idx_base_reg + ADDR_W'(instr_reg[7:0]);
		end else if (instr_reg[7:0] < ACCESS_SPLIT) begin
			eff_addr_next = ADDR_W'(instr_reg[7:0]);
		end else begin
			eff_addr_next = ADDR_W'({ACCESS_HI_BNK, instr_reg[7:0]});
		end
	end

	// Q1 decode latches address and destination
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			eff_addr_reg <= ADDR12_RST[ADDR_W-1:0];
			dest_reg     <= 1'b0;
		end else if (phase_reg == PH_Q1) begin
			eff_addr_reg <= eff_addr_next;
			dest_reg     <= instr_reg[POS_DEST];
		end
	end

	// Q2 read of the file register
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			operand_reg <= 8'h00;
		end else if (phase_reg == PH_Q2) begin
			operand_reg <= data_mem[eff_addr_reg];
		end
	end

	rotate_right_carry_unit u_rot (
		.operand_i (operand_reg),
		.carry_i   (status_reg[POS_C]),
		.result_o  (alu_result),
		.carry_o   (alu_carry),
		.neg_o     (alu_neg),
		.zero_o    (alu_zero)
	);

	// Q3 captures the rotated value and new flags
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			result_reg    <= 8'h00;
			carry_res_reg <= 1'b0;
			neg_res_reg   <= 1'b0;
			zero_res_reg  <= 1'b0;
		end else if (phase_reg == PH_Q3) begin
			result_reg    <= alu_result;
			carry_res_reg <= alu_carry;
			neg_res_reg   <= alu_neg;
			zero_res_reg  <= alu_zero;
		end
	end

	// Accumulator: bus write or Q4 result with dest clear
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			accum_reg <= ACCUM_RST;
		end else if (phase_reg == PH_Q4 && !dest_reg) begin
			accum_reg <= result_reg;
		end else if (wr_ok && AVS_ADDRESS_I == OFF_ACCUM) begin
			accum_reg <= accum_wr[7:0];
		end
	end

	// Status: only C, Z, N change on execution
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			status_reg <= STATUS_RST;
		end else if (phase_reg == PH_Q4) begin
			status_reg[POS_C] <= carry_res_reg;
			status_reg[POS_Z] <= zero_res_reg;
			status_reg[POS_N] <= neg_res_reg;
		end else if (wr_ok && AVS_ADDRESS_I == OFF_STATUS) begin
			status_reg <= status_wr[STATUS_W-1:0];
		end
	end

	// Bank select, mode and index base set by software
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			banksel_reg  <= BANKSEL_RST[BANK_W-1:0];
			ext_en_reg   <= 1'b0;
			idx_base_reg <= ADDR12_RST[ADDR_W-1:0];
			mem_addr_reg <= ADDR12_RST[ADDR_W-1:0];
		end else if (wr_ok) begin
			case (AVS_ADDRESS_I)
				OFF_BANKSEL: begin
					banksel_reg <= banksel_wr[BANK_W-1:0];
				end
				OFF_CONFIG: begin
					if (AVS_BYTEENABLE_I[0]) begin
						ext_en_reg <= AVS_WRITEDATA_I[POS_EXT_EN];
					end
				end
				OFF_IDX_BASE: begin
					idx_base_reg <= idx_base_wr[ADDR_W-1:0];
				end
				OFF_MEM_ADDR: begin
					mem_addr_reg <= mem_addr_wr[ADDR_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Data memory: Q4 write-back or bus window write, never both
	always_ff @(posedge CLK_I) begin
		if (phase_reg == PH_Q4 && dest_reg) begin
			data_mem[eff_addr_reg] <= result_reg;
		end else if (wr_ok && AVS_ADDRESS_I == OFF_MEM_DATA && AVS_BYTEENABLE_I[0]) begin
			data_mem[mem_addr_reg] <= AVS_WRITEDATA_I[7:0];
		end
	end

	// Read mux, unmapped addresses read zero
	always_comb begin
		rd_next = 32'h0000_0000;
		case (AVS_ADDRESS_I)
			OFF_INSTR: begin
				rd_next = {14'h0000, illegal_reg, busy, instr_reg};
			end
			OFF_ACCUM:    rd_next = 32'(accum_reg);
			OFF_STATUS:   rd_next = 32'(status_reg);
			OFF_BANKSEL:  rd_next = 32'(banksel_reg);
			OFF_CONFIG:   rd_next = 32'(ext_en_reg);
			OFF_IDX_BASE: rd_next = 32'(idx_base_reg);
			OFF_MEM_ADDR: rd_next = 32'(mem_addr_reg);
			OFF_MEM_DATA: rd_next = 32'(data_mem[mem_addr_reg]);
			default:      rd_next = 32'h0000_0000;
		endcase
	end

	// Registered read data costs one wait cycle per read
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rd_valid_reg   <= 1'b0;
			AVS_READDATA_O <= 32'h0000_0000;
		end else begin
			rd_valid_reg <= rd_start;
			if (rd_start) begin
				AVS_READDATA_O <= rd_next;
			end
		end
	end

endmodule
`default_nettype wire

// *** verilog/rrc_exec_pkg.sv ***
`default_nettype none
package rrc_exec_pkg;

	// Register byte addresses on the slave port
	localparam logic [4:0] OFF_INSTR     = 5'h00;
	localparam logic [4:0] OFF_ACCUM     = 5'h04;
	localparam logic [4:0] OFF_STATUS    = 5'h08;
	localparam logic [4:0] OFF_BANKSEL   = 5'h0C;
	localparam logic [4:0] OFF_CONFIG    = 5'h10;
	localparam logic [4:0] OFF_IDX_BASE  = 5'h14;
	localparam logic [4:0] OFF_MEM_ADDR  = 5'h18;
	localparam logic [4:0] OFF_MEM_DATA  = 5'h1C;

	// Instruction word layout
	localparam logic [5:0] RRC_OPCODE    = 6'h0C;
	localparam int         POS_OPC_LO    = 10;
	localparam int         POS_DEST      = 9;
	localparam int         POS_BANK      = 8;

	// Instruction register readback fields
	localparam int         POS_BUSY      = 16;
	localparam int         POS_ILLEGAL   = 17;

	// Status flag positions
	localparam int         POS_C         = 0;
	localparam int         POS_Z         = 2;
	localparam int         POS_N         = 4;
	localparam int         STATUS_W      = 5;

	// Operand limits and access bank split
	localparam logic [7:0] OPERAND_MAX   = 8'hFF;
	localparam logic [7:0] IDX_THRESHOLD = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT  = 8'h60;
	localparam logic [3:0] ACCESS_HI_BNK = 4'hF;
	localparam int         POS_EXT_EN    = 0;

	// Reset values
	localparam logic [15:0] INSTR_RST    = 16'h0000;
	localparam logic [7:0]  ACCUM_RST    = 8'h00;
	localparam logic [4:0]  STATUS_RST   = 5'h00;
	localparam logic [3:0]  BANKSEL_RST  = 4'h0;
	localparam logic [11:0] ADDR12_RST   = 12'h000;

	// Phases of one instruction cycle
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} exec_phase_e;

endpackage
`default_nettype wire
